// ==== hdl/sac_arbiter_counter.sv ====
`include "sac_regs.svh"
`default_nettype none
// Overview of operation
// - nine-bit up-counter with sticky overflow bit, readable by software
// - mode field: 00 idle/held, 01 bit time measure, 10 arbitration, 11 reserved
// - mode field read/write, cleared to idle by reset
// - arbitration lost flag read-only, cleared by writing upper mode bit zero
// - clock select 1: counter ticks at half the baud prescaler output rate
// - clock select 0: counter ticks at bus clock over four; bit resets to 0
// - prescaler source is bus clock or crystal clock per source-select bit
// - measurement done flag set on completion, cleared by control write or reset
// - running flag reads 1 while counting, 0 when stopped
// - overflow bit set on counter wrap, cleared by control write or reset
// - mode 00 clears the counter and holds it while selected
// - counter top bit readable in control, cleared by control write
// - measure, select 0: start and stop on receive falling edges
// - measure, select 1: start while receive low, stop at next rise
// - arbitration: transmit rise starts count; low receive at threshold sets lost
// - transmit pin forced high while arbitration lost flag is set
module sac_arbiter_counter (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line side
  input wire logic rxd_pin,
  input wire logic internal_transmit_out,
  input wire logic crystal_buffered_clk,
  output logic txd_pin,
  // interrupt
  output logic irq
);
  import sac_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  sac_ctrl_t ctrl_r;
  sac_evt_t sts_r, msk_r, evt;
  logic baud_src_sel_r;
  logic [7:0] psc_div_r, psc_cnt_r;
  logic [1:0] div4_r;
  logic half_r;
  logic [8:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;
  logic done_r, ovf_r, lost_r;
  logic seen_r, seen_nxt, smp_r, smp_nxt;
  logic rx_s, rx_d_r, xt_s, xt_d_r, tx_d_r;
  logic pready_r, pslverr_r, irq_r, txd_r;
  logic [31:0] prdata_r;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  sac_sync u_rx_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(rxd_pin),
    .q(rx_s)
  );
  sac_sync u_xt_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(crystal_buffered_clk),
    .q(xt_s)
  );

  // edge history: receive and crystal after the synchronisers, transmit taken unsynchronised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_d_r <= 1'b1;
      xt_d_r <= 1'b1;
      tx_d_r <= 1'b1;
    end else begin
      rx_d_r <= rx_s;
      xt_d_r <= xt_s;
      tx_d_r <= internal_transmit_out;
    end
  end

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire acc = psel & penable & pready_r;
  wire wr = acc & pwrite;
  wire hit_ctrl = (paddr == `SAC_OFS_CTRL);
  wire hit_cfg = (paddr == `SAC_OFS_CFG);
  wire hit_psc = (paddr == `SAC_OFS_PSC);
  wire hit_sts = (paddr == `SAC_OFS_IRQ_STS);
  wire hit_msk = (paddr == `SAC_OFS_IRQ_MSK);
  wire hit_any = hit_ctrl | hit_cfg | hit_psc | hit_sts | hit_msk;
  wire ctrl_wr = wr & hit_ctrl;
  wire rx_fall = rx_d_r & ~rx_s;
  wire rx_rise = ~rx_d_r & rx_s;
  wire tx_rise = ~tx_d_r & internal_transmit_out;
  wire tx_fall = tx_d_r & ~internal_transmit_out;
  wire [8:0] arb_thr = ctrl_r.aclk ? `SAC_ARB_THR_PSC : `SAC_ARB_THR_BUS;

  // ----------------------------------------
  // counter clock enables
  // ----------------------------------------
  // prescaler source select
  wire src_tick = baud_src_sel_r ? (xt_s & ~xt_d_r) : 1'b1;
  wire psc_tick = src_tick & (psc_cnt_r == psc_div_r);
  wire div4_tick = (div4_r == `SAC_DIV4_LAST);
  wire half_tick = psc_tick & half_r;
  wire tick = ctrl_r.aclk ? half_tick : div4_tick;

  // free-running dividers; enables only, never derived clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div4_r <= 2'h0;
      psc_cnt_r <= `SAC_RST_PSC;
      half_r <= 1'b0;
    end else begin
      div4_r <= div4_r + 2'h1;
      if (psc_tick) begin
        psc_cnt_r <= `SAC_RST_PSC;
        half_r <= ~half_r;
      end else if (src_tick) begin
        psc_cnt_r <= psc_cnt_r + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // arbiter counter
  // ----------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    seen_nxt = seen_r;
    smp_nxt = smp_r;
    evt = '0;
    if (run_r && tick) begin
      cnt_nxt = cnt_r + `SAC_CNT_ONE;
      evt.ovf = (cnt_r == `SAC_CNT_MAX);
    end
    unique case (ctrl_r.mode)
      SAC_MEAS: begin
        if (!ctrl_r.aclk) begin
          // falling edge starts, next falling edge stops
          if (rx_fall && run_r) begin
            run_nxt = 1'b0;
            cnt_nxt = cnt_r;
            evt.done = 1'b1;
          end else if (rx_fall) begin
            run_nxt = 1'b1;
            cnt_nxt = `SAC_CNT_ZERO;
          end
        end else begin
          // low level starts, rising edge stops; one shot until rearmed
          if (run_r && rx_rise) begin
            run_nxt = 1'b0;
            cnt_nxt = cnt_r;
            evt.done = 1'b1;
          end else if (!run_r && !rx_s && !done_r) begin
            run_nxt = 1'b1;
            cnt_nxt = `SAC_CNT_ZERO;
          end
        end
      end
      SAC_ARB: begin
        // transmit rise restarts, threshold samples receive once
        if (tx_rise) begin
          run_nxt = 1'b1;
          cnt_nxt = `SAC_CNT_ZERO;
          seen_nxt = 1'b0;
          smp_nxt = 1'b0;
        end else if (run_r) begin
          if (!rx_s) begin
            seen_nxt = 1'b1;
          end
          if (cnt_r == arb_thr && !smp_r) begin
            smp_nxt = 1'b1;
            evt.lost = ~rx_s;
          end
          // transmit low before the threshold sample, without a prior low on receive, aborts the slot
          if (tx_fall && !seen_r && !smp_r) begin
            run_nxt = 1'b0;
            cnt_nxt = `SAC_CNT_ZERO;
          end
        end
      end
      // idle and reserved hold counter cleared
      SAC_IDLE, SAC_RSVD: begin
        run_nxt = 1'b0;
        cnt_nxt = `SAC_CNT_ZERO;
      end
    endcase
    // any control write clears the whole counter
    if (ctrl_wr) begin
      cnt_nxt = `SAC_CNT_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= `SAC_CNT_ZERO;
      run_r <= 1'b0;
      seen_r <= 1'b0;
      smp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      seen_r <= seen_nxt;
      smp_r <= smp_nxt;
    end
  end

  // ----------------------------------------
  // status flags, set wins over clear
  // ----------------------------------------
  wire lost_clr = ctrl_wr & ~pwdata[`SAC_BIT_MODE_HI];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      ovf_r <= 1'b0;
      lost_r <= 1'b0;
    end else begin
      done_r <= evt.done | (done_r & ~ctrl_wr);
      ovf_r <= evt.ovf | (ovf_r & ~ctrl_wr);
      // lost flag cleared by upper mode bit written zero
      lost_r <= evt.lost | (lost_r & ~lost_clr);
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // mode and clock select writable; flags ignore write data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
      baud_src_sel_r <= 1'b0;
      psc_div_r <= `SAC_RST_PSC;
      msk_r <= `SAC_RST_IRQ;
    end else if (wr) begin
      if (hit_ctrl) begin
        ctrl_r.mode <= sac_mode_t'(pwdata[`SAC_BIT_MODE_HI:`SAC_BIT_MODE_LO]);
        ctrl_r.aclk <= pwdata[`SAC_BIT_ACLK];
      end
      if (hit_cfg) begin
        baud_src_sel_r <= pwdata[0];
      end
      if (hit_psc) begin
        psc_div_r <= pwdata[7:0];
      end
      if (hit_msk) begin
        msk_r <= pwdata[2:0];
      end
    end
  end

  // interrupt status: set wins over write-one-to-clear
  wire [2:0] sts_clr = (wr & hit_sts) ? pwdata[2:0] : 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r <= `SAC_RST_IRQ;
    end else begin
      sts_r <= evt | (sts_r & ~sts_clr);
    end
  end

  // ----------------------------------------
  // read mux and bus answer
  // ----------------------------------------
  wire [7:0] ctrl_rd = {ctrl_r.mode, lost_r, ctrl_r.aclk, done_r, run_r, ovf_r, cnt_r[8]};
  wire [31:0] rd_mux =
    hit_ctrl ? {24'h000000, ctrl_rd} :
    hit_cfg ? {31'h00000000, baud_src_sel_r} :
    hit_psc ? {24'h000000, psc_div_r} :
    hit_sts ? {29'h00000000, sts_r} :
    hit_msk ? {29'h00000000, msk_r} : 32'h00000000;

  // one wait state per access keeps every answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~hit_any;
      prdata_r <= (psel & penable & ~pready_r & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------
  // pin and interrupt outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      // lost arbitration holds the line recessive
      txd_r <= lost_r | internal_transmit_out;
      irq_r <= |(sts_r & msk_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign txd_pin = txd_r;
  assign irq = irq_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_arb_hit;
    ctrl_r.mode == SAC_ARB && run_r && !tx_rise && cnt_r == arb_thr && !smp_r;
  endsequence

  a_idle_holds_cnt: assert property (
    ctrl_r.mode == SAC_IDLE |=> cnt_r == `SAC_CNT_ZERO && !run_r)
    else $error("counter not held in idle");
  a_rsvd_like_idle: assert property (
    ctrl_r.mode == SAC_RSVD && !ctrl_wr |=> !run_r && $stable(done_r))
    else $error("reserved mode not idle");
  a_lost_forces_tx: assert property (
    lost_r |=> txd_pin)
    else $error("transmit not forced high");
  a_lost_clear_wr: assert property (
    lost_clr && !evt.lost |=> !lost_r)
    else $error("lost flag not cleared");
  a_ctrl_wr_clears: assert property (
    ctrl_wr && !evt.done && !evt.ovf |=> !done_r && !ovf_r && cnt_r == `SAC_CNT_ZERO)
    else $error("control write did not clear");
  a_wrap_sets_ovf: assert property (
    run_r && tick && cnt_r == `SAC_CNT_MAX |=> ovf_r)
    else $error("overflow not flagged");
  a_meas_stop_edge: assert property (
    ctrl_r.mode == SAC_MEAS && !ctrl_r.aclk && run_r && rx_fall |=> !run_r && done_r)
    else $error("measurement did not stop");
  a_arb_lost_set: assert property (
    s_arb_hit ##0 !rx_s |=> lost_r)
    else $error("arbitration loss missed");
  a_div4_spacing: assert property (
    div4_tick |=> !div4_tick [*3] ##1 div4_tick)
    else $error("bus divider not four");
  a_half_psc_rate: assert property (
    ctrl_r.aclk && ctrl_r.mode == SAC_MEAS && run_r && !ctrl_wr && !half_tick |=> $stable(cnt_r))
    else $error("prescaler half rate broken");
endmodule
`default_nettype wire

// ==== hdl/sac_regs.svh ====
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SAC_OFS_CTRL 12'h000
`define SAC_OFS_CFG 12'h004
`define SAC_OFS_PSC 12'h008
`define SAC_OFS_IRQ_STS 12'h00c
`define SAC_OFS_IRQ_MSK 12'h010
// ----------------------------------------
// control register bit positions
// ----------------------------------------
`define SAC_BIT_MODE_HI 7
`define SAC_BIT_MODE_LO 6
`define SAC_BIT_LOST 5
`define SAC_BIT_ACLK 4
`define SAC_BIT_DONE 3
`define SAC_BIT_RUN 2
`define SAC_BIT_OVF 1
`define SAC_BIT_TOP 0
// ----------------------------------------
// interrupt bits, reset values, counts
// ----------------------------------------
`define SAC_IRQ_DONE 0
`define SAC_IRQ_LOST 1
`define SAC_IRQ_OVF 2
`define SAC_RST_BYTE 8'h00
`define SAC_RST_PSC 8'h00
`define SAC_RST_IRQ 3'h0
`define SAC_CNT_ZERO 9'h000
`define SAC_CNT_ONE 9'h001
`define SAC_CNT_MAX 9'h1ff
`define SAC_ARB_THR_BUS 9'h038
`define SAC_ARB_THR_PSC 9'h008
`define SAC_DIV4_LAST 2'h3
`endif

// ==== hdl/sac_pkg.sv ====
`default_nettype none
package sac_pkg;
  // arbiter operating mode, in field code order
  typedef enum logic [1:0] {SAC_IDLE, SAC_MEAS, SAC_ARB, SAC_RSVD} sac_mode_t;
  // software-visible control state
  typedef struct packed {
    sac_mode_t mode;
    logic aclk;
  } sac_ctrl_t;
  // interrupt event vector
  typedef struct packed {
    logic ovf;
    logic lost;
    logic done;
  } sac_evt_t;
endpackage
`default_nettype wire

// ==== hdl/sac_sync.sv ====
`default_nettype none
module sac_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous level in, synchronised level out
  input wire logic d,
  output logic q
);
  logic meta_r;
  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ==== sim/sac_bus_node.sv ====
`default_nettype none
// ----------------------------------------
// other node on the shared serial line
// ----------------------------------------
module sac_bus_node (
  // our node's transmit pin
  input wire logic txd_pin,
  // other node drives the line dominant
  input wire logic pull_low,
  // level seen on the line
  output logic rxd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // wired-and with pull-up: a dominant low from either node wins
  assign rxd_pin = txd_pin & ~pull_low;
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`include "sac_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} sac_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic txd_pin;
  logic irq;
  logic rxd_pin;
  logic txi = 1'b1;
  logic xclk = 1'b0;
  logic dom = 1'b0;
  logic [31:0] r;
  logic e;
  int n_mismatch = 0;
  int n_compared = 0;
  sac_row_t rows [0:8] = '{
    '{`SAC_OFS_CTRL, 32'h10, 32'h10, 1'b0},
    '{`SAC_OFS_CTRL, 32'hd0, 32'hd0, 1'b0},
    '{`SAC_OFS_CTRL, 32'h2f, 32'h00, 1'b0},
    '{`SAC_OFS_CFG, 32'h1, 32'h1, 1'b0},
    '{`SAC_OFS_CFG, 32'hffffffff, 32'h1, 1'b0},
    '{`SAC_OFS_PSC, 32'h1a5, 32'ha5, 1'b0},
    '{`SAC_OFS_PSC, 32'h0, 32'h0, 1'b0},
    '{`SAC_OFS_IRQ_MSK, 32'hff, 32'h7, 1'b0},
    '{12'h014, 32'h5, 32'h0, 1'b1}};
  // ----------------------------------------
  // clocks, design and line model
  // ----------------------------------------
  always #10 pclk = ~pclk;
  // crystal seventeen times slower than the bus clock, rising edges on bus clock rising edges
  always #170 xclk = ~xclk;
  sac_arbiter_counter i_sac_arbiter_counter (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_pin(rxd_pin), .internal_transmit_out(txi), .crystal_buffered_clk(xclk),
    .txd_pin(txd_pin), .irq(irq));
  sac_bus_node i_sac_bus_node (.txd_pin(txd_pin), .pull_low(dom), .rxd_pin(rxd_pin));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      $display("mismatch %s expected %h seen %h", nm, x, g);
      n_mismatch++;
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never reassigns psel in this time step
    @(posedge pclk);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, r);
  endtask
  // two falling edges gap plus one cycles apart, running checked in between
  task automatic meas(input int gap, input logic [31:0] fin);
    dom <= 1'b1;
    cyc(20);
    dom <= 1'b0;
    cyc(40);
    rd(`SAC_OFS_CTRL, 32'h44, "running");
    cyc(gap - 63);
    dom <= 1'b1;
    cyc(20);
    dom <= 1'b0;
    cyc(20);
    rd(`SAC_OFS_CTRL, fin, "finished");
  endtask
  // other node dominant from s to s+l cycles after our transmit rise; md picks the clock
  task automatic arb(input int s, input int l, input logic lost, input logic [31:0] md);
    wr(`SAC_OFS_CTRL, 32'h00);
    wr(`SAC_OFS_CTRL, md);
    txi <= 1'b0;
    cyc(5);
    txi <= 1'b1;
    cyc(s);
    dom <= 1'b1;
    cyc(l);
    dom <= 1'b0;
    cyc(400 - s - l);
    apb(1'b0, `SAC_OFS_CTRL, 32'h0);
    chk("lost", {26'h0, lost, 5'h0}, r & 32'h20);
    txi <= 1'b0;
    cyc(3);
    chk("txd forced", {31'h0, lost}, {31'h0, txd_pin});
    wr(`SAC_OFS_CTRL, 32'h00);
    cyc(3);
    chk("txd freed", 32'h0, {31'h0, txd_pin});
    rd(`SAC_OFS_CTRL, 32'h0, "lost cleared");
    txi <= 1'b1;
    cyc(5);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (30000) @(posedge pclk);
    $display("mismatch watchdog expected end seen hang");
    n_mismatch++;
    end_sim();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(12);
    presetn <= 1'b1;
    cyc(1);
    chk("txd idle", 32'h1, {31'h0, txd_pin});
    for (int i = 0; i < 5; i++) begin
      rd(12'(4 * i), 32'h0, "reset value");
    end
    for (int i = 0; i < 9; i++) begin
      wr(rows[i].a, rows[i].d);
      chk("slverr", {31'h0, rows[i].e}, {31'h0, e});
      rd(rows[i].a, rows[i].q, "row");
    end
    $display("test registers done");
    // counter held in idle and reserved
    for (int i = 0; i < 2; i++) begin
      wr(`SAC_OFS_CTRL, i ? 32'hc0 : 32'h00);
      dom <= 1'b1;
      cyc(30);
      dom <= 1'b0;
      cyc(5);
      rd(`SAC_OFS_CTRL, i ? 32'hc0 : 32'h00, "held");
    end
    $display("test idle done");
    wr(`SAC_OFS_IRQ_MSK, 32'h0);
    wr(`SAC_OFS_CTRL, 32'h40);
    meas(1200, 32'h49);
    wr(`SAC_OFS_CTRL, 32'h40);
    rd(`SAC_OFS_CTRL, 32'h40, "write clears");
    meas(2200, 32'h4a);
    $display("test measure bus clock done");
    // half prescaler rate, bus or crystal source
    for (int i = 0; i < 2; i++) begin
      wr(`SAC_OFS_CFG, 32'(i));
      dom <= 1'b1;
      wr(`SAC_OFS_CTRL, 32'h50);
      cyc(800);
      rd(`SAC_OFS_CTRL, i ? 32'h54 : 32'h55, "low running");
      dom <= 1'b0;
      cyc(10);
      rd(`SAC_OFS_CTRL, i ? 32'h58 : 32'h59, "break length");
    end
    $display("test measure prescaler done");
    arb(20, 100, 1'b0, 32'h80);
    arb(180, 100, 1'b1, 32'h80);
    arb(320, 60, 1'b0, 32'h80);
    // half prescaler clock from the crystal: sample at the short threshold
    arb(200, 120, 1'b1, 32'h90);
    $display("test arbitration done");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`SAC_OFS_IRQ_MSK, 32'h2);
    cyc(3);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(`SAC_OFS_IRQ_STS, 32'h7);
    cyc(3);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(`SAC_OFS_IRQ_STS, 32'h0, "status");
    $display("test interrupt done");
    wr(`SAC_OFS_CTRL, 32'h90);
    presetn <= 1'b0;
    cyc(3);
    chk("txd in reset", 32'h1, {31'h0, txd_pin});
    presetn <= 1'b1;
    cyc(1);
    rd(`SAC_OFS_CTRL, 32'h0, "ctrl after reset");
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
